//--- hdl/bridge_system_control_straps.sv
// system control: reset, straps, clock ratio, machine check, quiesce, suspend
`timescale 1ns/1ps
`include "sysctl_map.svh"
module bridge_system_control_straps
    import sysctl_pkg::*;
#(
    parameter int DRAIN_CYC = `QUIESCE_DRAIN_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic hard_reset_in,
    input wire logic suspend_in,
    input wire logic fatal_error_in,
    input wire logic quiesce_request_in,
    input wire logic snoop_busy_in,
    input wire logic [`RATIO_W-1:0] ratio_select_in,
    input wire logic monitor_pll_sel_in,
    input wire logic map_select_strap,
    input wire logic rom0_width_strap,
    input wire logic rom_location_strap,
    input wire logic sw_map_wr,
    input wire logic [1:0] sw_map_wdata,
    input wire logic pci_mem_write_in,
    input wire logic write_recorded_in,
    input wire logic irq_clear_in,
    input wire logic ctl_data_in,
    input wire logic refresh_req_in,
    output logic machine_check_out,
    output logic quiesce_ack_out,
    output logic snoop_pause_out,
    output logic clock_monitor_out,
    output logic core_tick_out,
    output logic [1:0] clk_mode_out,
    output logic pll_bypass_out,
    output logic [1:0] addr_map_out,
    output logic rom0_is_8bit_out,
    output logic rom1_is_8bit_out,
    output logic rom_on_mem_bus_out,
    output logic modified_memory_irq,
    output logic ctl_data_out,
    output logic ctl_data_oe,
    output logic refresh_out,
    output logic suspended_out
);
    localparam int CNT_W = (DRAIN_CYC > 1) ? $clog2(DRAIN_CYC + 1) : 1;

    logic in_reset;
    logic live;
    logic hreset_q_ff;
    logic suspend_ff;
    logic nxt_suspend;
    logic strap_map_ff;
    logic strap_rom_w_ff;
    logic strap_rom_loc_ff;
    logic [1:0] map_ff;
    logic [1:0] nxt_map;
    logic mcp_ff;
    logic nxt_mcp;
    logic irq_ff;
    logic nxt_irq;
    logic [1:0] mode_ff;
    logic [1:0] nxt_mode;
    logic ctl_out_ff;
    quiesce_state_t qs_ff;
    quiesce_state_t nxt_qs;
    logic [CNT_W-1:0] drain_ff;
    logic [CNT_W-1:0] nxt_drain;
    logic drain_done;
    logic emu_write;
    logic core_tick;
    logic mon_clk;

    // suspend freezes straps, map, irq, mode and quiesce state and masks hard reset; ctl_data_in and refresh_req_in still pass through
    assign nxt_suspend = suspend_in;
    assign in_reset = hard_reset_in && !suspend_ff;
    assign live = !in_reset && !suspend_ff;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            suspend_ff <= 1'b0;
        end else begin
            suspend_ff <= nxt_suspend;
        end
    end

    // straps follow their pins while reset is held and one cycle after release, then freeze
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            hreset_q_ff <= 1'b1;
            strap_map_ff <= 1'b1;
            strap_rom_w_ff <= 1'b0;
            strap_rom_loc_ff <= 1'b0;
        end else begin
            hreset_q_ff <= in_reset;
            if (in_reset || hreset_q_ff) begin
                strap_map_ff <= map_select_strap;
                strap_rom_w_ff <= rom0_width_strap;
                strap_rom_loc_ff <= rom_location_strap;
            end
        end
    end

    // map A on high strap, B on low; emulation only by write after reset
    always_comb begin
        nxt_map = map_ff;
        if (in_reset || hreset_q_ff) begin
            nxt_map = map_select_strap ? `MAP_A : `MAP_B;
        end else if (live && sw_map_wr && sw_map_wdata <= `MAP_EMU) begin
            nxt_map = sw_map_wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            map_ff <= `MAP_A;
        end else begin
            map_ff <= nxt_map;
        end
    end

    // machine check follows fatal error input
    assign nxt_mcp = live && fatal_error_in;

    // modified-memory irq: set wins over clear
    assign emu_write = (map_ff == `MAP_EMU) && pci_mem_write_in && !write_recorded_in;
    assign nxt_irq = in_reset ? 1'b0 : (suspend_ff ? irq_ff : (emu_write || (irq_ff && !irq_clear_in)));

    // ratio select decoded every cycle outside suspend
    always_comb begin
        case (ratio_select_in)
            `RATIO_1TO1: nxt_mode = 2'(CK_1TO1);
            `RATIO_2TO1: nxt_mode = 2'(CK_2TO1);
            `RATIO_3TO1: nxt_mode = 2'(CK_3TO1);
            `RATIO_BYPASS: nxt_mode = 2'(CK_BYPASS);
            default: nxt_mode = mode_ff;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mcp_ff <= 1'b0;
            irq_ff <= 1'b0;
            mode_ff <= 2'(CK_1TO1);
            ctl_out_ff <= 1'b0;
        end else begin
            mcp_ff <= nxt_mcp;
            irq_ff <= nxt_irq;
            mode_ff <= suspend_ff ? mode_ff : nxt_mode;
            ctl_out_ff <= ctl_data_in;
        end
    end

    // quiesce: drain snooping traffic, then acknowledge until request drops
    assign drain_done = (drain_ff == CNT_W'(0)) && !snoop_busy_in;

    always_comb begin
        nxt_qs = qs_ff;
        nxt_drain = drain_ff;
        case (qs_ff)
            QS_RUN: begin
                if (quiesce_request_in) begin
                    nxt_qs = QS_DRAIN;
                    nxt_drain = CNT_W'(DRAIN_CYC);
                end
            end
            QS_DRAIN: begin
                if (drain_ff != CNT_W'(0)) begin
                    nxt_drain = drain_ff - CNT_W'(1);
                end
                if (!quiesce_request_in) begin
                    nxt_qs = QS_RUN;
                end else if (drain_done) begin
                    nxt_qs = QS_ACK;
                end
            end
            QS_ACK: begin
                if (!quiesce_request_in) begin
                    nxt_qs = QS_RUN;
                end
            end
            default: nxt_qs = QS_RUN;
        endcase
        if (in_reset) begin
            nxt_qs = QS_RUN;
            nxt_drain = CNT_W'(0);
        end else if (suspend_ff) begin
            nxt_qs = qs_ff;
            nxt_drain = drain_ff;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            qs_ff <= QS_RUN;
            drain_ff <= CNT_W'(0);
        end else begin
            qs_ff <= nxt_qs;
            drain_ff <= nxt_drain;
        end
    end

    core_clk_gen u_clk (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .mode(mode_ff),
        .mon_sel_pll(monitor_pll_sel_in),
        .core_tick(core_tick),
        .clock_monitor_out(mon_clk)
    );

    // outputs: check, ack, irq and ctl_data_oe inactive in reset; those and clock monitor released in suspend
    assign machine_check_out = mcp_ff && !suspend_ff;
    assign quiesce_ack_out = (qs_ff == QS_ACK) && !suspend_ff;
    assign snoop_pause_out = (qs_ff != QS_RUN);
    assign clock_monitor_out = mon_clk && !suspend_ff;
    assign core_tick_out = core_tick;
    assign clk_mode_out = mode_ff;
    assign pll_bypass_out = (mode_ff == 2'(CK_BYPASS));
    assign addr_map_out = map_ff;
    assign rom0_is_8bit_out = strap_rom_w_ff;
    assign rom1_is_8bit_out = 1'b0;
    assign rom_on_mem_bus_out = strap_rom_loc_ff;
    assign modified_memory_irq = irq_ff && !suspend_ff;
    assign ctl_data_out = ctl_out_ff;
    assign ctl_data_oe = live;
    assign refresh_out = refresh_req_in;
    assign suspended_out = suspend_ff;

    sequence s_req_held;
        quiesce_request_in && !in_reset && !suspend_ff && !suspend_in;
    endsequence

    chk_ack_needs_req: assert property (@(posedge clk_sys) disable iff (!rst_b)
        quiesce_ack_out |-> $past(quiesce_request_in))
        else $error("ack without request");
    chk_ack_after_drain: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(quiesce_ack_out) |-> !$past(snoop_busy_in))
        else $error("ack while snoop busy");
    chk_ack_holds: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (quiesce_ack_out ##0 s_req_held) |=> quiesce_ack_out)
        else $error("ack dropped while request held");
    chk_ack_release: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (quiesce_ack_out && !quiesce_request_in && !suspend_ff) |=> !quiesce_ack_out)
        else $error("ack not released");
    chk_mcp_follow: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (fatal_error_in && !hard_reset_in && !suspend_ff && !suspend_in) |=> machine_check_out)
        else $error("machine check missed");
    chk_reset_quiet: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (hard_reset_in && !suspend_ff) |-> !ctl_data_oe ##1 !machine_check_out)
        else $error("output active in reset");
    chk_suspend_float: assert property (@(posedge clk_sys) disable iff (!rst_b)
        suspend_ff |-> (!ctl_data_oe && !quiesce_ack_out && !clock_monitor_out))
        else $error("output driven in suspend");
    chk_no_emu_strap: assert property (@(posedge clk_sys) disable iff (!rst_b)
        hreset_q_ff |-> addr_map_out != `MAP_EMU)
        else $error("emulation map from strap");
    chk_map_strap: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (in_reset && map_select_strap) |=> addr_map_out == `MAP_A)
        else $error("map strap ignored");
    chk_ratio_live: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (ratio_select_in == `RATIO_3TO1 && !suspend_ff) |=> clk_mode_out == 2'(CK_3TO1))
        else $error("ratio not followed");
    chk_irq_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (emu_write && !in_reset && !suspend_ff) |=> irq_ff)
        else $error("irq missed");

    // strap capture, sticky irq and frozen state
    chk_map_from_strap: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $fell(hreset_q_ff) |-> addr_map_out == (strap_map_ff ? `MAP_A : `MAP_B))
        else $error("map differs from latched strap");
    chk_emu_only_sw: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (in_reset || hreset_q_ff) |=> addr_map_out != `MAP_EMU)
        else $error("emulation map during reset");
    chk_irq_sticky: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (irq_ff && !irq_clear_in && !in_reset && !suspend_ff) |=> irq_ff)
        else $error("irq dropped without clear");
    chk_ack_pause: assert property (@(posedge clk_sys) disable iff (!rst_b)
        quiesce_ack_out |-> snoop_pause_out)
        else $error("ack while snooping resumed");
    chk_mode_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (ratio_select_in > 4'h3 && !suspend_ff) |=> clk_mode_out == $past(clk_mode_out))
        else $error("unknown ratio code changed mode");
    chk_suspend_mode: assert property (@(posedge clk_sys) disable iff (!rst_b)
        suspend_ff |=> clk_mode_out == $past(clk_mode_out))
        else $error("mode changed in suspend");
endmodule : bridge_system_control_straps

//--- hdl/sysctl_map.svh
// constants for the bridge system-control block
`ifndef SYSCTL_MAP_SVH
`define SYSCTL_MAP_SVH
`define RATIO_W 4
`define RATIO_1TO1 4'h1
`define RATIO_2TO1 4'h2
`define RATIO_3TO1 4'h3
`define RATIO_BYPASS 4'h0
`define QUIESCE_DRAIN_NS 200
`define CLK_PERIOD_NS 50
`define QUIESCE_DRAIN_CYC ((`QUIESCE_DRAIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MAP_SEL_W 2
`define MAP_A 2'h0
`define MAP_B 2'h1
`define MAP_EMU 2'h2
`endif

//--- hdl/sysctl_pkg.sv
// types for the bridge system-control block
package sysctl_pkg;
    typedef enum logic [1:0] {
        ADDR_MAP_A,
        ADDR_MAP_B,
        ADDR_MAP_EMU
    } addr_map_t;
    typedef enum logic [1:0] {
        QS_RUN,
        QS_DRAIN,
        QS_ACK
    } quiesce_state_t;
    typedef enum logic [1:0] {
        CK_BYPASS,
        CK_1TO1,
        CK_2TO1,
        CK_3TO1
    } clk_mode_t;
endpackage : sysctl_pkg

//--- hdl/core_clk_gen.sv
// core clock divider model and monitor clock select
`timescale 1ns/1ps
module core_clk_gen
    import sysctl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [1:0] mode,
    input wire logic mon_sel_pll,
    output logic core_tick,
    output logic clock_monitor_out
);
    logic [1:0] cnt_ff;
    logic [1:0] nxt_cnt;
    logic [1:0] last_idx;
    logic mon_ff;
    logic nxt_mon;

    // core ticks count system cycles per ratio step
    assign last_idx = (mode == 2'(CK_3TO1)) ? 2'h2 : ((mode == 2'(CK_2TO1)) ? 2'h1 : 2'h0);
    assign nxt_cnt = (cnt_ff >= last_idx) ? 2'h0 : cnt_ff + 2'h1;
    assign nxt_mon = mon_sel_pll ? (cnt_ff == 2'h0) : ~mon_ff;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= 2'h0;
            mon_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            mon_ff <= nxt_mon;
        end
    end

    assign core_tick = (cnt_ff == 2'h0);
    assign clock_monitor_out = mon_ff;

    chk_tick_period: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (mode == 2'(CK_2TO1) && $stable(mode) && core_tick) |=> !core_tick)
        else $error("core tick too often in 2:1");
endmodule : core_clk_gen

//--- dv/host_model.sv
// host processor model driving the quiesce request
`timescale 1ns/1ps
module host_model (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic want,
    input wire logic slow,
    input wire logic quiesce_ack_out,
    output logic quiesce_request_in
);
    logic [1:0] lag_ff;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            quiesce_request_in <= 1'b0;
            lag_ff <= 2'h0;
        end else if (want) begin
            lag_ff <= 2'h0;
            quiesce_request_in <= 1'b1;
        end else if (slow && quiesce_ack_out && quiesce_request_in && lag_ff != 2'h3) begin
            // a slow host keeps asking a few acknowledged cycles after it is done
            lag_ff <= lag_ff + 2'h1;
        end else begin
            quiesce_request_in <= 1'b0;
        end
    end
endmodule : host_model

//--- dv/testbench.sv
// self-checking bench for the system-control block
`timescale 1ns/1ps
`include "sysctl_map.svh"
module testbench;
    import sysctl_pkg::*;
    typedef struct packed {logic [3:0] sel; logic [1:0] mode; logic byp;} ratio_row_t;
    ratio_row_t rows [6] = '{'{4'h1, 2'h1, 1'b0}, '{4'h2, 2'h2, 1'b0}, '{4'h3, 2'h3, 1'b0},
                             '{4'h0, 2'h0, 1'b1}, '{4'hF, 2'h0, 1'b1}, '{4'h2, 2'h2, 1'b0}};
    logic clk_sys = 1'b0, rst_b = 1'b0, hard_reset_in = 1'b0, suspend_in = 1'b0, fatal_error_in = 1'b0;
    logic snoop_busy_in = 1'b0, monitor_pll_sel_in = 1'b0, map_select_strap = 1'b1, rom0_width_strap = 1'b1;
    logic rom_location_strap = 1'b1, sw_map_wr = 1'b0, pci_mem_write_in = 1'b0, write_recorded_in = 1'b0;
    logic irq_clear_in = 1'b0, ctl_data_in = 1'b0, refresh_req_in = 1'b0, want = 1'b0, slow = 1'b0;
    logic [3:0] ratio_select_in = 4'h1;
    logic [1:0] sw_map_wdata = 2'h0, clk_mode_out, addr_map_out;
    logic quiesce_request_in, machine_check_out, quiesce_ack_out, snoop_pause_out, clock_monitor_out;
    logic core_tick_out, pll_bypass_out, rom0_is_8bit_out, rom1_is_8bit_out, rom_on_mem_bus_out;
    logic modified_memory_irq, ctl_data_out, ctl_data_oe, refresh_out, suspended_out, mon_last;
    int n_mismatch = 0, cmp_count = 0, toggles, ticks;
    always #25 clk_sys = ~clk_sys;
    host_model host_u (.clk_sys(clk_sys), .rst_b(rst_b), .want(want), .slow(slow),
        .quiesce_ack_out(quiesce_ack_out), .quiesce_request_in(quiesce_request_in));
    bridge_system_control_straps #(.DRAIN_CYC(1)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
        .hard_reset_in(hard_reset_in), .suspend_in(suspend_in), .fatal_error_in(fatal_error_in),
        .quiesce_request_in(quiesce_request_in), .snoop_busy_in(snoop_busy_in), .ratio_select_in(ratio_select_in),
        .monitor_pll_sel_in(monitor_pll_sel_in), .map_select_strap(map_select_strap),
        .rom0_width_strap(rom0_width_strap), .rom_location_strap(rom_location_strap), .sw_map_wr(sw_map_wr),
        .sw_map_wdata(sw_map_wdata), .pci_mem_write_in(pci_mem_write_in), .write_recorded_in(write_recorded_in),
        .irq_clear_in(irq_clear_in), .ctl_data_in(ctl_data_in), .refresh_req_in(refresh_req_in),
        .machine_check_out(machine_check_out), .quiesce_ack_out(quiesce_ack_out),
        .snoop_pause_out(snoop_pause_out), .clock_monitor_out(clock_monitor_out), .core_tick_out(core_tick_out),
        .clk_mode_out(clk_mode_out), .pll_bypass_out(pll_bypass_out), .addr_map_out(addr_map_out),
        .rom0_is_8bit_out(rom0_is_8bit_out), .rom1_is_8bit_out(rom1_is_8bit_out),
        .rom_on_mem_bus_out(rom_on_mem_bus_out), .modified_memory_irq(modified_memory_irq),
        .ctl_data_out(ctl_data_out), .ctl_data_oe(ctl_data_oe), .refresh_out(refresh_out),
        .suspended_out(suspended_out));
    task end_sim;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task step(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : step
    task wait_ack(input logic v);
        for (int i = 0; i < 50; i++) begin
            if (quiesce_ack_out === v) return;
            step(1);
        end
        n_mismatch++;
        end_sim();
    endtask : wait_ack
    task map_wr(input logic [1:0] v);
        @(posedge clk_sys) begin sw_map_wr <= 1'b1; sw_map_wdata <= v; end
        @(posedge clk_sys) sw_map_wr <= 1'b0;
        step(1);
    endtask : map_wr
    initial begin
        step(8);
        @(posedge clk_sys) rst_b <= 1'b1;
        step(3);
        @(posedge clk_sys) begin map_select_strap <= 1'b0; rom0_width_strap <= 1'b0; rom_location_strap <= 1'b0; end
        step(2);
        chk(addr_map_out, `MAP_A);
        chk(rom0_is_8bit_out, 1'b1);
        chk(rom1_is_8bit_out, 1'b0);
        chk(rom_on_mem_bus_out, 1'b1);
        chk({machine_check_out, quiesce_ack_out}, 2'h0);
        foreach (rows[i]) begin
            @(posedge clk_sys) ratio_select_in <= rows[i].sel;
            step(3);
            chk(clk_mode_out, rows[i].mode);
            chk(pll_bypass_out, rows[i].byp);
        end
        for (int m = 0; m < 2; m++) begin
            @(posedge clk_sys) monitor_pll_sel_in <= m[0];
            step(2);
            toggles = 0;
            ticks = 0;
            mon_last = clock_monitor_out;
            for (int i = 0; i < 8; i++) begin
                step(1);
                if (clock_monitor_out !== mon_last) toggles++;
                if (core_tick_out === 1'b1) ticks++;
                mon_last = clock_monitor_out;
            end
            chk(toggles > 0, 1'b1);
            chk(8'(ticks), 8'h04);
        end
        @(posedge clk_sys) fatal_error_in <= 1'b1;
        step(2);
        chk(machine_check_out, 1'b1);
        @(posedge clk_sys) fatal_error_in <= 1'b0;
        step(2);
        chk(machine_check_out, 1'b0);
        map_wr(`MAP_EMU);
        chk(addr_map_out, `MAP_EMU);
        map_wr(2'h3);
        chk(addr_map_out, `MAP_EMU);
        @(posedge clk_sys) begin pci_mem_write_in <= 1'b1; write_recorded_in <= 1'b1; end
        @(posedge clk_sys) pci_mem_write_in <= 1'b0;
        step(2);
        chk(modified_memory_irq, 1'b0);
        @(posedge clk_sys) begin pci_mem_write_in <= 1'b1; write_recorded_in <= 1'b0; end
        @(posedge clk_sys) pci_mem_write_in <= 1'b0;
        step(3);
        chk(modified_memory_irq, 1'b1);
        @(posedge clk_sys) irq_clear_in <= 1'b1;
        @(posedge clk_sys) irq_clear_in <= 1'b0;
        step(2);
        chk(modified_memory_irq, 1'b0);
        @(posedge clk_sys) begin pci_mem_write_in <= 1'b1; irq_clear_in <= 1'b1; end
        @(posedge clk_sys) begin pci_mem_write_in <= 1'b0; irq_clear_in <= 1'b0; end
        step(2);
        chk(modified_memory_irq, 1'b1);
        for (int s = 0; s < 2; s++) begin
            @(posedge clk_sys) begin snoop_busy_in <= (s == 0); slow <= s[0]; want <= 1'b1; end
            step(10);
            chk(snoop_pause_out, 1'b1);
            chk(quiesce_ack_out, s[0]);
            @(posedge clk_sys) snoop_busy_in <= 1'b0;
            wait_ack(1'b1);
            @(posedge clk_sys) want <= 1'b0;
            step(3);
            chk(quiesce_ack_out, s[0]);
            wait_ack(1'b0);
            step(1);
            chk(snoop_pause_out, 1'b0);
        end
        @(posedge clk_sys) ctl_data_in <= 1'b1;
        step(2);
        chk({ctl_data_out, ctl_data_oe}, 2'h3);
        @(posedge clk_sys) begin hard_reset_in <= 1'b1; fatal_error_in <= 1'b1; map_select_strap <= 1'b0; end
        step(3);
        chk({machine_check_out, ctl_data_oe, modified_memory_irq}, 3'h0);
        @(posedge clk_sys) begin hard_reset_in <= 1'b0; fatal_error_in <= 1'b0; end
        step(3);
        chk(addr_map_out, `MAP_B);
        chk(rom0_is_8bit_out, 1'b0);
        chk(rom_on_mem_bus_out, 1'b0);
        @(posedge clk_sys) begin suspend_in <= 1'b1; map_select_strap <= 1'b1; end
        step(2);
        chk(suspended_out, 1'b1);
        @(posedge clk_sys) begin fatal_error_in <= 1'b1; hard_reset_in <= 1'b1; refresh_req_in <= 1'b1; end
        step(3);
        chk({machine_check_out, ctl_data_oe, refresh_out}, 3'h1);
        @(posedge clk_sys) hard_reset_in <= 1'b0;
        step(3);
        chk(addr_map_out, `MAP_B);
        end_sim();
    end
endmodule : testbench
